// ---- core/awl_core.v ----
// Alibi weighing logger: save checks, two-part ID counters, save
// reply, readback with ID check, whole-log wipe and register port.
// Assumes save, key, readback and exit inputs are one-cycle pulses
// synchronous to sys_clk; weights are signed counts of divisions.
//
// Functional notes
// - Each save advances weighing count by one
// - After maximum, weighing restarts, rewrite increments
// - Rewrite count reported as five decimal digits
// - Weighing count reported as six decimal digits
// - Save starts by serial command or key
// - Successful save sends gross, tare and ID
// - Save needs weight nonnegative, stable, in range
// - Approved mode needs weight over twenty divisions
// - Key save needs print reactivation permission
// - Failed command replies NO; failed key silent
// - Same rewrite, weighing not above last: valid
// - Previous rewrite, weighing above last: valid
// - Readback takes rewrite 0-255, weighing to maximum
// - Verified readback offers scale, unit, gross, tare
// - Empty log shows empty for one second
// - Unverified ID shows invalid, returns to weighing
// - Wipe erases all, refused when approved
`timescale 1ns/1ps
`include "awl_defines.vh"
module awl_core #(
  parameter DEPTH     = 16,             // Records held on chip
  parameter AW        = 4,              // Record index width
  parameter EMPTY_CYC = `AWL_EMPTY_MS * `AWL_CLK_KHZ // Empty hold
) (
  input  wire        sys_clk,           // 125 MHz clock
  input  wire        rst,               // Async reset, high
  input  wire [7:0]  reg_addr,          // Register byte address
  input  wire [31:0] reg_wdata,         // Register write data
  input  wire        reg_wr,            // Write strobe
  input  wire        reg_rd,            // Read strobe
  output wire [31:0] reg_rdata,         // Read data, next cycle
  output wire        irq,               // Level interrupt
  input  wire        save_with_id_command, // Serial save request
  input  wire        save_key,          // Front-panel save key
  input  wire        print_reactivate_ok, // Key print permitted
  input  wire        weight_stable,     // Weight is stable
  input  wire        weight_underload,  // Below range
  input  wire        weight_overload,   // Above range
  input  wire [3:0]  scale_num,         // Active scale number
  input  wire [1:0]  unit_code,         // Unit of measurement
  input  wire [23:0] gross,             // Signed gross, divisions
  input  wire [23:0] tare,              // Signed tare, divisions
  output wire        tx_valid,          // Reply ready, one cycle
  output wire        tx_no_id,          // Reply carries NO
  output wire [23:0] tx_gross,          // Reply gross weight
  output wire [23:0] tx_tare,           // Reply tare
  output wire [19:0] tx_rewrite_bcd,    // Rewrite, 5 BCD digits
  output wire [23:0] tx_weigh_bcd,      // Weighing, 6 BCD digits
  input  wire        rd_req,            // Readback request
  input  wire [7:0]  rewrite_count_prompt, // Rewrite to read
  input  wire [17:0] rd_weigh,          // Weighing to read
  input  wire [1:0]  rd_item_sel,       // Item on display
  input  wire        rd_exit,           // Leave readback
  output wire        rd_showing,        // Record on display
  output wire [23:0] rd_item,           // Selected item value
  output wire        show_empty,        // Empty-log indication
  output wire        show_invalid       // Invalid-ID pulse
);

  localparam RW = 54;                   // Record width
  localparam [2:0] ST_IDLE  = 3'h1;     // Weighing mode
  localparam [2:0] ST_EMPTY = 3'h2;     // Empty notice held
  localparam [2:0] ST_SHOW  = 3'h4;     // Record on display
  localparam [26:0] EMPTY_LAST = EMPTY_CYC[26:0] - 27'h0000001;

  // Double-dabble to packed BCD, six digits
  function [23:0] awl_bcd;
    input [17:0] bin;
    integer i;
    integer j;
    reg [23:0] b;
    begin
      b = 24'h000000;
      for (i = 17; i >= 0; i = i - 1) begin
        for (j = 0; j < 6; j = j + 1) begin
          if (b[j*4 +: 4] > 4'h4) begin
            b[j*4 +: 4] = b[j*4 +: 4] + 4'h3;
          end
        end
        b = {b[22:0], bin[i]};
      end
      awl_bcd = b;
    end
  endfunction

  reg  [1:0]         ctrl_ff;           // Enable and approved
  reg  [`AWL_EVT_W-1:0] sts_ff;         // Sticky events
  reg  [`AWL_EVT_W-1:0] mask_ff;        // Interrupt mask
  reg  [31:0]        rdata_ff;          // Read data
  reg  [7:0]         nrw_ff;            // Next rewrite to issue
  reg  [17:0]        nw_ff;             // Next weighing to issue
  reg  [7:0]         lrw_ff;            // Last issued rewrite
  reg  [17:0]        lw_ff;             // Last issued weighing
  reg                empty_ff;          // Nothing saved since wipe
  reg                txv_ff;            // Reply strobe
  reg                txno_ff;           // Reply without ID
  reg  [23:0]        txg_ff;            // Reply gross
  reg  [23:0]        txt_ff;            // Reply tare
  reg  [19:0]        txr_ff;            // Reply rewrite BCD
  reg  [23:0]        txw_ff;            // Reply weighing BCD
  reg  [2:0]         st_ff;             // Readback state
  reg  [26:0]        tmr_ff;            // Empty display timer
  reg  [RW-1:0]      rec_ff;            // Record on display
  reg  [23:0]        item_ff;           // Item shown
  reg                inv_ff;            // Invalid pulse
  reg  [2:0]         nxt_st;            // Next readback state
  reg  [31:0]        nxt_rdata;         // Next read data
  reg  [23:0]        nxt_item;          // Next shown item

  wire               appr = ctrl_ff[`AWL_CTRL_APPR];
  wire               wipe;              // Accepted wipe
  wire               cond_ok;           // Weight allows a save
  wire               key_go;            // Key save attempt
  wire               save_go;           // Save to be stored
  wire               at_max;            // Weighing at maximum
  wire               rd_hit;            // Store holds that ID
  wire [RW-1:0]      rd_rec;            // Record from store
  wire               id_ok;             // Requested ID verifies
  wire               rd_go;             // Readback taken
  wire               wr_hit = reg_wr && (reg_addr == `AWL_REG_STATUS);
  wire [`AWL_EVT_W-1:0] evt;            // This cycle's events
  wire [23:0]        rw_bcd = awl_bcd({10'h000, nrw_ff}); // Top digit 0

  assign wipe = reg_wr && (reg_addr == `AWL_REG_CTRL) &&
                reg_wdata[`AWL_CTRL_WIPE] && !appr;

  assign cond_ok = ctrl_ff[`AWL_CTRL_EN] && !gross[23] &&
                   weight_stable && !weight_underload &&
                   !weight_overload &&
                   (!appr || (gross > `AWL_MIN_DIV));

  // key needs permission
  // The command outranks a key press in the same cycle
  assign key_go  = save_key && !save_with_id_command &&
                   print_reactivate_ok;
  assign save_go = cond_ok && (save_with_id_command || key_go);
  assign at_max  = (nw_ff == `AWL_WEIGH_MAX);

  // Control, mask and read data registers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff  <= `AWL_CTRL_RST;
      mask_ff  <= `AWL_MASK_RST;
      rdata_ff <= 32'h00000000;
    end else begin
      if (reg_wr && (reg_addr == `AWL_REG_CTRL)) begin
        ctrl_ff <= reg_wdata[1:0];
      end
      if (reg_wr && (reg_addr == `AWL_REG_MASK)) begin
        mask_ff <= reg_wdata[`AWL_EVT_W-1:0];
      end
      // Data stand only in the cycle after the read strobe
      rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
    end
  end

  // Read decode; unmapped offsets read as zero
  always @* begin
    nxt_rdata = 32'h00000000;
    case (reg_addr)
      `AWL_REG_CTRL:   nxt_rdata[1:0] = ctrl_ff;
      `AWL_REG_STATUS: nxt_rdata[`AWL_EVT_W-1:0] = sts_ff;
      `AWL_REG_MASK:   nxt_rdata[`AWL_EVT_W-1:0] = mask_ff;
      `AWL_REG_ID: begin
        nxt_rdata[`AWL_ID_WLSB +: 18] = lw_ff;
        nxt_rdata[`AWL_ID_RLSB +: 8]  = lrw_ff;
        nxt_rdata[`AWL_ID_EMPTY]      = empty_ff;
      end
      default:         nxt_rdata = 32'h00000000;
    endcase
  end

  assign evt[`AWL_EVT_SAVE]   = save_go;
  assign evt[`AWL_EVT_REFUSE] = save_with_id_command && !cond_ok;
  assign evt[`AWL_EVT_RD_OK]  = rd_go && id_ok && !empty_ff;
  assign evt[`AWL_EVT_RD_BAD] = rd_go && (!id_ok || empty_ff);
  assign evt[`AWL_EVT_WIPE]   = wipe;

  // Sticky status; a new event wins over a write-one clear
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sts_ff <= {`AWL_EVT_W{1'b0}};
    end else begin
      sts_ff <= (sts_ff & ~(wr_hit ? reg_wdata[`AWL_EVT_W-1:0] :
                 {`AWL_EVT_W{1'b0}})) | evt;
    end
  end

  assign irq = |(sts_ff & mask_ff);

  // ID counters
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nrw_ff   <= 8'h00;
      nw_ff    <= 18'h00000;
      lrw_ff   <= 8'h00;
      lw_ff    <= 18'h00000;
      empty_ff <= 1'b1;
    end else if (wipe) begin
      // Wiping starts the log afresh
      nrw_ff   <= 8'h00;
      nw_ff    <= 18'h00000;
      lrw_ff   <= 8'h00;
      lw_ff    <= 18'h00000;
      empty_ff <= 1'b1;
    end else if (save_go) begin
      lrw_ff   <= nrw_ff;
      lw_ff    <= nw_ff;
      empty_ff <= 1'b0;
      if (at_max) begin
        // wrap and next pass
        // Rewrite count wraps past 255 with its 8-bit width
        nw_ff  <= 18'h00000;
        nrw_ff <= nrw_ff + 8'h01;
      end else begin
        nw_ff  <= nw_ff + 18'h00001;
      end
    end
  end

  // Save reply; key refusals send nothing
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txv_ff  <= 1'b0;
      txno_ff <= 1'b0;
      txg_ff  <= 24'h000000;
      txt_ff  <= 24'h000000;
      txr_ff  <= 20'h00000;
      txw_ff  <= 24'h000000;
    end else begin
      txv_ff  <= save_go || save_with_id_command;
      txno_ff <= !save_go;
      if (save_go || save_with_id_command) begin
        txg_ff <= gross;
        txt_ff <= tare;
        txr_ff <= rw_bcd[19:0];
        txw_ff <= awl_bcd(nw_ff);
      end
    end
  end

  assign tx_valid       = txv_ff;
  assign tx_no_id       = txno_ff;
  assign tx_gross       = txg_ff;
  assign tx_tare        = txt_ff;
  assign tx_rewrite_bcd = txr_ff;
  assign tx_weigh_bcd   = txw_ff;

  awl_store #(
    .DEPTH (DEPTH),
    .AW    (AW),
    .TW    (26),
    .DW    (RW)
  ) u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (save_go && !wipe),
    .wr_idx  (nw_ff[AW-1:0]),
    .wr_tag  ({nrw_ff, nw_ff}),
    .wr_data ({scale_num, unit_code, gross, tare}),
    .wipe    (wipe),
    .rd_idx  (rd_weigh[AW-1:0]),
    .rd_tag  ({rewrite_count_prompt, rd_weigh}),
    .rd_hit  (rd_hit),
    .rd_data (rd_rec)
  );

  assign id_ok = rd_hit && (rd_weigh <= `AWL_WEIGH_MAX) &&
    (((rewrite_count_prompt == lrw_ff) && (rd_weigh <= lw_ff)) ||
     ((lrw_ff != 8'h00) &&
      (rewrite_count_prompt == lrw_ff - 8'h01) &&
      (rd_weigh > lw_ff)));

  // Requests made away from weighing mode are ignored
  assign rd_go = rd_req && (st_ff == ST_IDLE);

  // Readback state choice
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (rd_go && empty_ff) begin
          nxt_st = ST_EMPTY;
        end else if (rd_go && id_ok) begin
          nxt_st = ST_SHOW;
        end
      end
      ST_EMPTY: begin
        if (tmr_ff == EMPTY_LAST) begin
          nxt_st = ST_IDLE;
        end
      end
      ST_SHOW: begin
        // A wipe also drops a record from the display
        if (rd_exit || wipe) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Readback state, timer and captured record
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff  <= ST_IDLE;
      tmr_ff <= 27'h0000000;
      rec_ff <= {RW{1'b0}};
      inv_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (st_ff == ST_EMPTY) begin
        tmr_ff <= tmr_ff + 27'h0000001;
      end else begin
        tmr_ff <= 27'h0000000;
      end
      inv_ff <= rd_go && !empty_ff && !id_ok;
      if (rd_go && id_ok) begin
        rec_ff <= rd_rec;
      end
    end
  end

  always @* begin
    nxt_item = 24'h000000;
    case (rd_item_sel)
      `AWL_ITEM_SCALE: nxt_item[3:0] = rec_ff[53:50];
      `AWL_ITEM_UNIT:  nxt_item[1:0] = rec_ff[49:48];
      `AWL_ITEM_GROSS: nxt_item = rec_ff[47:24];
      `AWL_ITEM_TARE:  nxt_item = rec_ff[23:0];
      default:         nxt_item = 24'h000000;
    endcase
  end

  // Shown item register; zero while nothing is displayed
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      item_ff <= 24'h000000;
    end else begin
      item_ff <= (st_ff == ST_SHOW) ? nxt_item : 24'h000000;
    end
  end

  assign rd_showing   = (st_ff == ST_SHOW);
  assign rd_item      = item_ff;
  assign show_empty   = (st_ff == ST_EMPTY);
  assign show_invalid = inv_ff;
  assign reg_rdata    = rdata_ff;

endmodule

// ---- pkg/awl_defines.vh ----
// Constants for the alibi weighing logger: register map, field
// positions, reset values, counter limits and timing.
// Assumes a single 125 MHz system clock.
`ifndef AWL_DEFINES_VH
`define AWL_DEFINES_VH

// Register byte offsets
`define AWL_REG_CTRL    8'h00
`define AWL_REG_STATUS  8'h04
`define AWL_REG_MASK    8'h08
`define AWL_REG_ID      8'h0C

// Control register fields
`define AWL_CTRL_EN     0
`define AWL_CTRL_APPR   1
`define AWL_CTRL_WIPE   2
`define AWL_CTRL_RST    2'h1

// Event bits in status and mask
`define AWL_EVT_SAVE    0
`define AWL_EVT_REFUSE  1
`define AWL_EVT_RD_OK   2
`define AWL_EVT_RD_BAD  3
`define AWL_EVT_WIPE    4
`define AWL_EVT_W       5
`define AWL_MASK_RST    5'h00

// ID register fields
`define AWL_ID_WLSB     0
`define AWL_ID_RLSB     18
`define AWL_ID_EMPTY    31

// Counter limits and acceptance threshold (in divisions)
`define AWL_WEIGH_MAX   18'h20000
`define AWL_MIN_DIV     24'h000014

// Readback item selectors
`define AWL_ITEM_SCALE  2'h0
`define AWL_ITEM_UNIT   2'h1
`define AWL_ITEM_GROSS  2'h2
`define AWL_ITEM_TARE   2'h3

// Timing
`define AWL_CLK_KHZ     125000
`define AWL_EMPTY_MS    1000

`endif

// ---- core/awl_store.v ----
// Record store of the alibi weighing logger: flip-flop entries
// indexed by the low bits of the weighing count, each tagged with
// the full ID so an aliased entry never answers for another.
// Assumes one write at a time and a wipe that outranks the write.
`timescale 1ns/1ps
module awl_store #(
  parameter DEPTH = 16,                 // Entries held
  parameter AW    = 4,                  // Index width
  parameter TW    = 26,                 // Tag (ID) width
  parameter DW    = 54                  // Record width
) (
  input  wire          sys_clk,         // System clock
  input  wire          rst,             // Async reset, high
  input  wire          wr_en,           // Store one record
  input  wire [AW-1:0] wr_idx,          // Entry to write
  input  wire [TW-1:0] wr_tag,          // ID of the record
  input  wire [DW-1:0] wr_data,         // Record contents
  input  wire          wipe,            // Erase all entries
  input  wire [AW-1:0] rd_idx,          // Entry to look up
  input  wire [TW-1:0] rd_tag,          // ID being asked for
  output wire          rd_hit,          // Entry holds that ID
  output wire [DW-1:0] rd_data          // Record contents
);

  reg [DW-1:0] data_ff [0:DEPTH-1];     // Record payloads
  reg [TW-1:0] tag_ff  [0:DEPTH-1];     // IDs of the records
  reg          vld_ff  [0:DEPTH-1];     // Entry holds a record

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          vld_ff[g]  <= 1'b0;
          tag_ff[g]  <= {TW{1'b0}};
          data_ff[g] <= {DW{1'b0}};
        end else if (wipe) begin
          // No per-entry erase exists: all valids drop together
          vld_ff[g] <= 1'b0;
        end else if (wr_en && (wr_idx == g)) begin
          vld_ff[g]  <= 1'b1;
          tag_ff[g]  <= wr_tag;
          data_ff[g] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_hit  = vld_ff[rd_idx] && (tag_ff[rd_idx] == rd_tag);
  assign rd_data = data_ff[rd_idx];

endmodule

// ---- dv/awl_core_asserts.sv ----
// Port assertions for the alibi weighing logger.
// Bound to awl_core and sees only its top ports.
`timescale 1ns/1ps
module awl_core_asserts #(
  parameter EMPTY_CYC = 20              // Empty notice length
) (
  input wire        sys_clk,            // Clock
  input wire        rst,                // Async reset
  input wire        save_with_id_command, // Host save
  input wire        save_key,           // Key save
  input wire        print_reactivate_ok, // Key allowed
  input wire        weight_stable,      // Stable
  input wire [23:0] gross,              // Gross weight
  input wire        tx_valid,           // Reply strobe
  input wire        tx_no_id,           // Reply is NO
  input wire [19:0] tx_rewrite_bcd,     // Rewrite digits
  input wire [23:0] tx_weigh_bcd,       // Weighing digits
  input wire        rd_req,             // Readback ask
  input wire        rd_showing,         // Record shown
  input wire        show_empty,         // Empty notice
  input wire        show_invalid        // Invalid notice
);
  int empty_cnt;                        // Cycles notice stood
  int last_w;                           // Last issued count
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Decimal value of six digits; -1 flags a digit above nine
  function automatic int dec(input [23:0] b);
    dec = 0;
    for (int i = 5; i >= 0; i--) begin
      if (b[i*4 +: 4] > 4'h9)
        return -1;
      dec = dec * 10 + b[i*4 +: 4];
    end
  endfunction
  // Notice length and last count, so steps span replies
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      empty_cnt <= 0;
      last_w    <= -1;
    end else begin
      empty_cnt <= show_empty ? empty_cnt + 1 : 0;
      if (tx_valid && !tx_no_id)
        last_w <= dec(tx_weigh_bcd);
    end
  end
  a_cmd_reply: assert property (
    save_with_id_command |=> tx_valid) else $error("no reply");
  a_cmd_refused: assert property (
    save_with_id_command && (gross[23] || !weight_stable) |=> tx_no_id)
    else $error("bad weight accepted");
  a_key_denied: assert property (
    save_key && !print_reactivate_ok && !save_with_id_command
    |=> !tx_valid) else $error("key save without permission");
  a_key_quiet: assert property (
    save_key && !save_with_id_command && !weight_stable |=> !tx_valid)
    else $error("refused key sent a reply");
  // Zero is allowed after a wrap or a wipe
  a_weigh_step: assert property (
    tx_valid && !tx_no_id |-> dec(tx_weigh_bcd) == last_w + 1
    || dec(tx_weigh_bcd) == 0) else $error("count did not step by one");
  a_rewrite_field: assert property (
    tx_valid |-> dec({4'h0, tx_rewrite_bcd}) inside {[0:255]})
    else $error("rewrite field out of range");
  a_weigh_field: assert property (
    tx_valid |-> dec(tx_weigh_bcd) inside {[0:131072]})
    else $error("weighing field out of range");
  a_invalid_pulse: assert property (
    show_invalid |=> !show_invalid && !rd_showing)
    else $error("invalid notice not a pulse");
  a_empty_time: assert property (
    $fell(show_empty) |-> empty_cnt == EMPTY_CYC)
    else $error("empty notice wrong length");
  c_save_ok: cover property (tx_valid && !tx_no_id);
  c_save_no: cover property (tx_valid && tx_no_id);
  c_empty: cover property (rd_req ##1 show_empty);
endmodule
bind awl_core awl_core_asserts #(.EMPTY_CYC(EMPTY_CYC)) awl_core_asserts_inst (
  .sys_clk, .rst, .save_with_id_command, .save_key, .print_reactivate_ok,
  .weight_stable, .gross, .tx_valid, .tx_no_id, .tx_rewrite_bcd,
  .tx_weigh_bcd, .rd_req, .rd_showing, .show_empty, .show_invalid);

// ---- dv/awl_host_model.sv ----
// Host on the PC serial port: sends the save command, keeps reply.
// Assumes one command in flight at a time.
`timescale 1ns/1ps
module awl_host_model (
  input  wire sys_clk,                  // Clock
  input  wire rst,                      // Async reset
  input  wire send,                     // Bench asks for a save
  input  wire tx_valid,                 // Reply strobe
  input  wire tx_no_id,                 // Reply is NO
  output reg  save_with_id_command,     // Save command pulse
  output reg  reply_seen,               // Reply arrived
  output reg  reply_no                  // Reply carried NO
);
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      save_with_id_command <= 1'h0;
      reply_seen           <= 1'h0;
      reply_no             <= 1'h0;
    end else begin
      save_with_id_command <= send;
      // Clear on a new ask so a stale reply never counts
      if (send)
        reply_seen <= 1'h0;
      else if (tx_valid) begin
        reply_seen <= 1'h1;
        reply_no   <= tx_no_id;
      end
    end
  end
endmodule

// ---- dv/awl_core_tb_top.sv ----
// Bench for awl_core: save table, keys, readback, wipe, interrupt.
// Assumes the host model issues serial saves.
`timescale 1ns/1ps
`include "awl_defines.vh"
module awl_core_tb_top;
  localparam EC = 20;                   // Short empty hold
  logic        sys_clk, rst, reg_wr, reg_rd, irq, send, seen, no;
  logic [7:0]  reg_addr, rewrite_count_prompt;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        save_with_id_command, save_key, print_reactivate_ok;
  logic        weight_stable, weight_underload, weight_overload;
  logic [3:0]  scale_num;
  logic [1:0]  unit_code, rd_item_sel;
  logic [23:0] gross, tare, tx_gross, tx_tare, tx_weigh_bcd, rd_item;
  logic [19:0] tx_rewrite_bcd;
  logic [17:0] rd_weigh;
  logic        tx_valid, tx_no_id, rd_req, rd_exit, rd_showing;
  logic        show_empty, show_invalid;
  int          err_total = 0, tests_run = 0, exp_id = 0, tx_cnt = 0, n;
  // Reset values per register, unmapped last
  logic [7:0]  ra [5] = '{`AWL_REG_CTRL, `AWL_REG_STATUS, `AWL_REG_MASK,
                          `AWL_REG_ID, 8'h10};
  logic [31:0] rv [5] = '{32'h1, 32'h0, 32'h0, 32'h80000000, 32'h0};
  // Rows: gross, stable, under, over, approved, accepted
  logic [28:0] rows [8] = '{{24'h5, 5'h11}, {24'h0, 5'h11},
    {24'hFFFFFF, 5'h10}, {24'h5, 5'h00}, {24'h5, 5'h18},
    {24'h5, 5'h14}, {24'h14, 5'h12}, {24'h15, 5'h13}};
  logic [23:0] items [4] = '{24'h5, 24'h2, 24'h7, 24'h107};
  awl_core #(.EMPTY_CYC(EC)) awl_core_inst (.sys_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .save_with_id_command,
    .save_key, .print_reactivate_ok, .weight_stable, .weight_underload,
    .weight_overload, .scale_num, .unit_code, .gross, .tare, .tx_valid,
    .tx_no_id, .tx_gross, .tx_tare, .tx_rewrite_bcd, .tx_weigh_bcd, .rd_req,
    .rewrite_count_prompt, .rd_weigh, .rd_item_sel, .rd_exit, .rd_showing,
    .rd_item, .show_empty, .show_invalid);
  awl_host_model awl_host_model_inst (.sys_clk, .rst, .send, .tx_valid,
    .tx_no_id, .save_with_id_command, .reply_seen(seen), .reply_no(no));
  // Clock, 8 ns period
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Counts every reply pulse, for silent-key checks
  always @(posedge sys_clk)
    if (tx_valid === 1'h1)
      tx_cnt++;
  function automatic [23:0] bcd(input int v);
    bcd = 24'h0;
    for (int k = 0; k < 6; k++) begin
      bcd[k*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
  endfunction
  task chk_val(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a, output [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  // Reply comes one cycle after the command, which trails send
  task cmd;
    @(posedge sys_clk);
    send <= 1'h1;
    @(posedge sys_clk);
    send <= 1'h0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task rdb(input [7:0] r, input [17:0] w);
    @(posedge sys_clk);
    rd_req <= 1'h1;
    rewrite_count_prompt <= r;
    rd_weigh <= w;
    @(posedge sys_clk);
    rd_req <= 1'h0;
    #1;
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    rst = 1'h1;
    {reg_wr, reg_rd, send, save_key, rd_req, rd_exit} = 6'h00;
    {print_reactivate_ok, weight_underload, weight_overload} = 3'h0;
    {reg_addr, reg_wdata, rd_item_sel, rewrite_count_prompt} = 50'h0;
    {rd_weigh, gross, tare} = 66'h0;
    weight_stable = 1'h1;
    scale_num = 4'h5;
    unit_code = 2'h2;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d);
      chk_val(d, rv[i]);
    end
    $display("done: reset values");
    for (int i = 0; i < 8; i++) begin
      wr(`AWL_REG_CTRL, {30'h0, rows[i][1], 1'h1});
      @(posedge sys_clk);
      {gross, weight_stable, weight_underload, weight_overload} <=
        rows[i][28:2];
      tare <= 24'h100 + 24'(i);
      cmd();
      chk_flag(seen, 1'h1);
      chk_flag(no, !rows[i][0]);
      if (rows[i][0]) begin
        chk_val(tx_gross, rows[i][28:5]);
        chk_val(tx_tare, 24'h100 + 24'(i));
        chk_val(tx_weigh_bcd, bcd(exp_id));
        chk_val(tx_rewrite_bcd, 32'h0);
        exp_id++;
      end
    end
    $display("done: save table");
    wr(`AWL_REG_CTRL, 32'h1);
    @(posedge sys_clk);
    gross <= 24'h7;
    for (int k = 0; k < 3; k++) begin
      n = tx_cnt;
      @(posedge sys_clk);
      print_reactivate_ok <= (k > 0);
      weight_stable <= (k != 1);
      save_key <= 1'h1;
      @(posedge sys_clk);
      save_key <= 1'h0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk_val(tx_cnt, n + (k == 2));
    end
    chk_val(tx_weigh_bcd, bcd(exp_id));
    $display("done: key saves");
    @(posedge sys_clk);
    scale_num <= 4'h9;
    rdb(8'h00, 18'h3);
    chk_flag(rd_showing, 1'h1);
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      rd_item_sel <= 2'(s);
      @(posedge sys_clk);
      #1;
      chk_val(rd_item, items[s]);
    end
    @(posedge sys_clk);
    rd_exit <= 1'h1;
    @(posedge sys_clk);
    rd_exit <= 1'h0;
    for (int j = 0; j < 2; j++) begin
      rdb(8'(j), j ? 18'h0 : 18'h4);
      chk_flag(show_invalid, 1'h1);
    end
    $display("done: readback");
    // Wipe is judged on the mode already set, so approve first
    wr(`AWL_REG_CTRL, 32'h3);
    wr(`AWL_REG_CTRL, 32'h7);
    rd(`AWL_REG_ID, d);
    chk_val(d, 32'h3);
    wr(`AWL_REG_CTRL, 32'h1);
    wr(`AWL_REG_CTRL, 32'h5);
    rd(`AWL_REG_ID, d);
    chk_val(d, 32'h80000000);
    rdb(8'h00, 18'h0);
    n = 0;
    while (show_empty === 1'h1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_val(n, EC);
    cmd();
    chk_val(tx_weigh_bcd, bcd(0));
    $display("done: wipe");
    wr(`AWL_REG_STATUS, 32'h1F);
    wr(`AWL_REG_MASK, 32'h2);
    cmd();
    chk_flag(irq, 1'h0);
    @(posedge sys_clk);
    weight_stable <= 1'h0;
    cmd();
    chk_flag(irq, 1'h1);
    rd(`AWL_REG_STATUS, d);
    chk_val(d, 32'h3);
    wr(`AWL_REG_STATUS, 32'h2);
    @(posedge sys_clk);
    #1;
    chk_flag(irq, 1'h0);
    $display("done: interrupt");
    give_verdict();
  end
endmodule
